//--- dv/wwd_rstc_model.sv
// Behavioural reset controller answering the watchdog reset requests
`timescale 1ns/1ps
module wwd_rstc_model (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic por_i,
  // Requests from the watchdog
  input wire logic req_all_i,
  input wire logic req_proc_i,
  // Reset back into the watchdog and processor
  output logic wd_rst_o
);
  logic [3:0] cnt_ff;

  // Slow answer: eight idle cycles, then eight cycles of reset
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      cnt_ff <= 4'h0;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff + 4'h1;
    end else if (req_all_i || req_proc_i) begin
      cnt_ff <= 4'h1;
    end
  end

  // Either kind resets the watchdog along with the processor
  assign wd_rst_o = cnt_ff[3];
endmodule

//--- dv/wwd_top_tb_top.sv
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
module wwd_top_tb_top;
  import wwd_pkg::*;
  typedef struct packed {logic we; logic [7:0] adr; logic [31:0] dat;} wwd_row_t;
  logic clk_i = 1'b0;
  logic por = 1'b1;
  logic wd_rst;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = 8'h00;
  logic [DAT_W-1:0] wdat = 32'h0000_0000;
  logic [DAT_W-1:0] dat_o;
  logic ack_o, fault_o, all_o, proc_o, irq_o;
  logic slck = 1'b0;
  logic dbg = 1'b0;
  logic idle = 1'b0;
  logic ce = 1'b1;
  logic [DAT_W-1:0] q;
  int errors = 0;
  int checks = 0;
  int n;
  wwd_row_t rows[11] = '{
    '{1'b0, 8'h04, 32'h3FFF_2FFF}, '{1'b0, 8'h08, 32'h0}, '{1'b0, 8'h00, 32'h0},
    '{1'b0, 8'h0C, 32'h0}, '{1'b1, 8'h00, 32'h5A00_0001}, '{1'b1, 8'h00, 32'hA500_0001},
    '{1'b0, 8'h08, 32'h0}, '{1'b1, 8'h04, 32'hC000_1002}, '{1'b0, 8'h04, 32'h0000_1002},
    '{1'b1, 8'h04, 32'h3FFF_2FFF}, '{1'b0, 8'h04, 32'h0000_1002}};

  always #50 clk_i = ~clk_i;
  // Slow clock tick every second cycle keeps a counter step at 256 cycles
  always @(posedge clk_i) slck <= ~slck;

  wwd_rstc_model i_wwd_rstc_model (.clk_i(clk_i), .por_i(por), .req_all_i(all_o),
    .req_proc_i(proc_o), .wd_rst_o(wd_rst));
  wwd_top i_wwd_top (.clk_i(clk_i), .rst_i(por | wd_rst), .ce_i(ce), .cyc_i(cyc),
    .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(SEL_ALL), .dat_i(wdat), .dat_o(dat_o),
    .ack_o(ack_o), .slck_tick_i(slck), .debug_i(dbg), .idle_i(idle), .fault_o(fault_o),
    .rst_req_all_o(all_o), .rst_req_proc_o(proc_o), .irq_o(irq_o));

  task automatic tally_and_finish();
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    q = dat_o;
    cyc <= 1'b0;
    if (k >= 50) chk_bit(ack_o, 1'b1);
  endtask

  task automatic reset_dut(input int len);
    @(posedge clk_i);
    por <= 1'b1;
    repeat (len) @(posedge clk_i);
    por <= 1'b0;
  endtask

  task automatic wait_irq(input int lim);
    n = 0;
    while (irq_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  // Fault with reset enabled; the model resets the watchdog
  task automatic fault_reset(input logic [31:0] mode, input logic ea, input logic ep);
    reset_dut(2);
    wb(1'b1, OFS_MODE, mode);
    n = 0;
    while (fault_o !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    chk_bit(fault_o, 1'b1);
    chk_bit(all_o, ea);
    chk_bit(proc_o, ep);
    repeat (20) @(posedge clk_i);
    chk_bit(fault_o, 1'b0);
    wb(1'b0, OFS_STAT, 32'h0);
    chk_word(q, 32'h0);
    wb(1'b0, OFS_MODE, 32'h0);
    chk_word(q, MODE_RESET);
  endtask

  // Stopped timer never underflows; a halt lifted lets it run again
  // A low clock enable freezes the whole timer like a halt
  task automatic halt_case(input logic [31:0] mode, input logic d, input logic i, input logic r,
                           input logic c);
    reset_dut(2);
    dbg <= d;
    idle <= i;
    wb(1'b1, OFS_MODE, mode);
    ce <= c;
    repeat (1200) @(posedge clk_i);
    chk_bit(irq_o, 1'b0);
    dbg <= 1'b0;
    idle <= 1'b0;
    ce <= 1'b1;
    wait_irq(700);
    chk_bit(irq_o, r);
  endtask

  initial begin
    #3000000;
    errors++;
    tally_and_finish();
  end

  initial begin
    reset_dut(12);
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we) chk_word(q, rows[i].dat);
    end
    // Counter 2 above delta 0: restart is a window error
    wb(1'b1, OFS_CTRL, 32'hA500_0001);
    repeat (2) @(posedge clk_i);
    chk_bit(fault_o, 1'b1);
    chk_bit(irq_o, 1'b1);
    chk_bit(all_o | proc_o, 1'b0);
    wb(1'b0, OFS_STAT, 32'h0);
    chk_word(q, 32'h0000_0002);
    @(posedge clk_i);
    chk_bit(fault_o | irq_o, 1'b0);
    // Regular restarts hold the counter off underflow
    reset_dut(2);
    wb(1'b1, OFS_MODE, 32'h0FFF_1001);
    for (int i = 0; i < 6; i++) begin
      repeat (200) @(posedge clk_i);
      wb(1'b1, OFS_CTRL, 32'hA500_0001);
      chk_bit(irq_o, 1'b0);
    end
    wait_irq(1000);
    chk_bit(n >= 500 && n <= 525, 1'b1);
    chk_bit(fault_o, 1'b0);
    repeat (600) @(posedge clk_i);
    wb(1'b0, OFS_STAT, 32'h0);
    chk_word(q, 32'h0000_0001);
    wb(1'b0, OFS_STAT, 32'h0);
    chk_word(q, 32'h0);
    fault_reset(32'h0FFF_2001, 1'b1, 1'b0);
    fault_reset(32'h0FFF_6001, 1'b0, 1'b1);
    halt_case(32'h0FFF_9001, 1'b0, 1'b0, 1'b0, 1'b1);
    halt_case(32'h1FFF_1001, 1'b1, 1'b0, 1'b1, 1'b1);
    halt_case(32'h2FFF_1001, 1'b0, 1'b1, 1'b1, 1'b1);
    halt_case(32'h0FFF_1001, 1'b0, 1'b0, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule

//--- rtl/wwd_pkg.sv
// Package of constants for the windowed watchdog timer
// Function
// - A 12-bit down counter is loaded from the counter reload value field.
// - The counter steps once per 128 slow clock ticks.
// - After reset the reload value is all ones and fault reset is enabled.
// - The mode register takes only its first write after reset; reads always work.
// - A mode register write reloads the counter and restarts counting like a restart.
// - A valid restart reloads the counter and clears the divide-by-128 prescaler.
// - A control write acts only with password byte 0xA5 and restart bit set.
// - Underflow sets its flag and, with fault reset enabled, raises the fault.
// - A restart above the delta window sets the error flag and fault, even disabled.
// - A delta window at or above the reload value never flags a restart error.
// - Interrupt is high while a status flag is set and interrupt enable is 1.
// - With fault reset enabled, processor-only bit picks processor or all resets.
// - A status read or any reset clears both flags, interrupt and fault.
// - Each status flag stays set until the next status register read.
// - A watchdog reset also resets the watchdog and clears both flags.
// - The disable bit stops the timer; clearing it keeps the timer enabled.
// - With debug halt set, the counter stops while the processor is in debug.
// - With idle halt set, the counter stops while the system is idle.
package wwd_pkg;

  // Bus geometry
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam logic [3:0] SEL_ALL = 4'hF;

  // Register offsets
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_MODE = 8'h04;
  localparam logic [ADR_W-1:0] OFS_STAT = 8'h08;

  // Control register layout
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_KEY_LO = 24;
  localparam int CTRL_KEY_HI = 31;
  localparam logic [7:0] CTRL_KEY = 8'hA5;

  // Mode register layout
  localparam int MODE_WDV_LO = 0;
  localparam int MODE_WDV_HI = 11;
  localparam int MODE_FIEN = 12;
  localparam int MODE_RSTEN = 13;
  localparam int MODE_PROC = 14;
  localparam int MODE_DIS = 15;
  localparam int MODE_WDD_LO = 16;
  localparam int MODE_WDD_HI = 27;
  localparam int MODE_DBGHLT = 28;
  localparam int MODE_IDLEHLT = 29;
  localparam logic [DAT_W-1:0] MODE_RESET = 32'h3FFF_2FFF;
  localparam logic [DAT_W-1:0] MODE_MASK = 32'h3FFF_FFFF;

  // Status register layout
  localparam int STAT_UNF = 0;
  localparam int STAT_ERR = 1;

  // Counter and prescaler
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam int PRE_DIV = 128;
  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_LAST = 7'h7F;
  localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;

endpackage

//--- rtl/wwd_presc.sv
// Divide-by-128 prescaler on the slow clock tick
`timescale 1ns/1ps
module wwd_presc (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control
  input wire logic clear_i,
  input wire logic run_i,
  input wire logic slck_tick_i,
  // Divided tick
  output logic tick_o
);
  import wwd_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } wwd_pre_st_t;

  wwd_pre_st_t q_ff;
  wwd_pre_st_t nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (clear_i) begin
      nxt_q.cnt = PRE_ZERO;
    end else if (run_i && slck_tick_i) begin
      nxt_q.cnt = q_ff.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else if (ce_i) begin
      q_ff <= nxt_q;
    end
  end

  // Wraps after the last of 128 slow ticks
  assign tick_o = run_i && slck_tick_i && !clear_i && (q_ff.cnt == PRE_LAST);

  property p_clear_zero;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && clear_i) |=> (q_ff.cnt == PRE_ZERO);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("prescaler not cleared by restart");

endmodule

//--- rtl/wwd_top.sv
// Windowed watchdog timer with classic Wishbone register slave
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module wwd_top (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [wwd_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [wwd_pkg::DAT_W-1:0] dat_i,
  output logic [wwd_pkg::DAT_W-1:0] dat_o,
  output logic ack_o,
  // Time base and system state
  input wire logic slck_tick_i,
  input wire logic debug_i,
  input wire logic idle_i,
  // Fault and interrupt
  output logic fault_o,
  output logic rst_req_all_o,
  output logic rst_req_proc_o,
  output logic irq_o
);
  import wwd_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [DAT_W-1:0] mode;
    logic locked;
    logic unf;
    logic err;
    logic fault;
    logic ack;
    logic [DAT_W-1:0] rdata;
  } wwd_st_t;

  wwd_st_t q_ff;
  wwd_st_t nxt_q;

  logic req;
  logic wr_go;
  logic rd_go;
  logic restart;
  logic mode_wr;
  logic stat_rd;
  logic win_err;
  logic run;
  logic tick;
  logic unf_evt;
  logic [CNT_W-1:0] counter_reload_value;
  logic [CNT_W-1:0] delta_window_value;
  logic disabled;
  logic rsten;
  logic proc_only;
  logic fien;

  // Mode fields as currently held
  assign counter_reload_value = q_ff.mode[MODE_WDV_HI:MODE_WDV_LO];
  assign delta_window_value = q_ff.mode[MODE_WDD_HI:MODE_WDD_LO];
  assign fien = q_ff.mode[MODE_FIEN];
  assign rsten = q_ff.mode[MODE_RSTEN];
  assign proc_only = q_ff.mode[MODE_PROC];
  assign disabled = q_ff.mode[MODE_DIS];

  // Bus decode
  assign req = cyc_i && stb_i;
  // Writes act at the edge where ack is sampled high
  assign wr_go = req && we_i && q_ff.ack && (sel_i == SEL_ALL);
  // Reads are captured at the edge that raises ack
  assign rd_go = req && !we_i && !q_ff.ack;

  // Key-checked restart; a wrong key drops the whole write
  assign restart = wr_go && (adr_i == OFS_CTRL) &&
                   (dat_i[CTRL_KEY_HI:CTRL_KEY_LO] == CTRL_KEY) &&
                   dat_i[CTRL_RESTART];

  // Only the first mode write after reset lands
  assign mode_wr = wr_go && (adr_i == OFS_MODE) && !q_ff.locked;

  assign stat_rd = rd_go && (adr_i == OFS_STAT);

  // Window check runs whether or not the timer is disabled
  assign win_err = restart && (q_ff.cnt > delta_window_value);

  // Halt conditions freeze counter and prescaler together
  assign run = !disabled &&
               !(q_ff.mode[MODE_DBGHLT] && debug_i) &&
               !(q_ff.mode[MODE_IDLEHLT] && idle_i);

  assign unf_evt = tick && (q_ff.cnt == CNT_ZERO);

  wwd_presc u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(restart || mode_wr),
    .run_i(run),
    .slck_tick_i(slck_tick_i),
    .tick_o(tick)
  );

  always_comb begin
    nxt_q = q_ff;

    // Counter: mode write, then restart, then tick
    if (mode_wr) begin
      nxt_q.cnt = dat_i[MODE_WDV_HI:MODE_WDV_LO];
    end else if (restart) begin
      nxt_q.cnt = counter_reload_value;
    end else if (tick) begin
      if (q_ff.cnt == CNT_ZERO) begin
        // Reload after underflow so the period repeats
        nxt_q.cnt = counter_reload_value;
      end else begin
        nxt_q.cnt = q_ff.cnt - 12'h001;
      end
    end

    // Write-once mode register
    if (mode_wr) begin
      nxt_q.mode = dat_i & MODE_MASK;
      nxt_q.locked = 1'b1;
    end

    // Status read clears; events in the same cycle win
    if (stat_rd) begin
      nxt_q.unf = 1'b0;
      nxt_q.err = 1'b0;
      nxt_q.fault = 1'b0;
    end
    if (unf_evt) begin
      nxt_q.unf = 1'b1;
    end
    if (win_err) begin
      nxt_q.err = 1'b1;
    end
    if ((unf_evt && rsten) || win_err) begin
      nxt_q.fault = 1'b1;
    end

    // Single-cycle ack for any address, mapped or not
    nxt_q.ack = req && !q_ff.ack;

    // Read data captured as ack rises
    if (rd_go) begin
      nxt_q.rdata = '0;
      if (adr_i == OFS_MODE) begin
        nxt_q.rdata = q_ff.mode;
      end else if (adr_i == OFS_STAT) begin
        nxt_q.rdata[STAT_UNF] = q_ff.unf;
        nxt_q.rdata[STAT_ERR] = q_ff.err;
      end
    end
  end

  // Processor reset, which the reset controller also drives on a watchdog reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff.cnt <= MODE_RESET[MODE_WDV_HI:MODE_WDV_LO];
      q_ff.mode <= MODE_RESET;
      q_ff.locked <= 1'b0;
      q_ff.unf <= 1'b0;
      q_ff.err <= 1'b0;
      q_ff.fault <= 1'b0;
      q_ff.ack <= 1'b0;
      q_ff.rdata <= '0;
    end else if (ce_i) begin
      q_ff <= nxt_q;
    end
  end

  // Outputs
  assign dat_o = q_ff.rdata;
  assign ack_o = q_ff.ack;
  assign fault_o = q_ff.fault;
  assign rst_req_all_o = q_ff.fault && rsten && !proc_only;
  assign rst_req_proc_o = q_ff.fault && rsten && proc_only;
  assign irq_o = (q_ff.unf || q_ff.err) && fien;

  // Checks

  property p_reset_mode;
    @(posedge clk_i)
    rst_i |=> (q_ff.mode == MODE_RESET) && (q_ff.cnt == counter_reload_value) && !fault_o;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("mode or counter wrong after reset");

  property p_mode_locked;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_go && (adr_i == OFS_MODE) && q_ff.locked) |=> $stable(q_ff.mode);
  endproperty
  a_mode_locked: assert property (p_mode_locked)
    else $error("mode register changed after first write");

  property p_mode_reload;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && mode_wr) |=> (q_ff.cnt == $past(dat_i[MODE_WDV_HI:MODE_WDV_LO])) && q_ff.locked;
  endproperty
  a_mode_reload: assert property (p_mode_reload)
    else $error("mode write did not reload counter");

  property p_restart_reload;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && restart && !mode_wr) |=> (q_ff.cnt == $past(counter_reload_value));
  endproperty
  a_restart_reload: assert property (p_restart_reload)
    else $error("restart did not reload counter");

  property p_bad_key;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_go && (adr_i == OFS_CTRL) &&
     (dat_i[CTRL_KEY_HI:CTRL_KEY_LO] != CTRL_KEY) && !tick)
    |=> $stable(q_ff.cnt) && !($rose(q_ff.err));
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("write with wrong key had an effect");

  property p_underflow;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && tick && (q_ff.cnt == CNT_ZERO)) |=>
      q_ff.unf && (q_ff.fault == $past(rsten) || $past(q_ff.fault) || $past(win_err));
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("underflow not flagged");

  property p_window_err;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && restart && (q_ff.cnt > delta_window_value)) |=> ##[0:1] (q_ff.err && fault_o);
  endproperty
  a_window_err: assert property (p_window_err)
    else $error("restart outside window not flagged");

  property p_window_ok;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && restart && (delta_window_value >= counter_reload_value) && !q_ff.err && !unf_evt) |=> !q_ff.err;
  endproperty
  a_window_ok: assert property (p_window_ok)
    else $error("restart flagged with open window");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && (unf_evt || win_err) && fien && !mode_wr) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("fault did not raise interrupt");

  property p_req_split;
    @(posedge clk_i) disable iff (rst_i)
    fault_o |-> ((rst_req_all_o || rst_req_proc_o) == rsten) && !(rst_req_all_o && rst_req_proc_o);
  endproperty
  a_req_split: assert property (p_req_split)
    else $error("reset request routing wrong");

  property p_read_clear;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && stat_rd && !unf_evt && !win_err) |=> !q_ff.unf && !q_ff.err && !fault_o && !irq_o;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear flags");

  property p_sticky;
    @(posedge clk_i) disable iff (rst_i)
    (q_ff.unf && !stat_rd) |=> q_ff.unf;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("underflow flag dropped without read");

  property p_disabled_hold;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && disabled && !restart && !mode_wr) |=> $stable(q_ff.cnt);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("counter moved while disabled");

  property p_debug_halt;
    @(posedge clk_i) disable iff (rst_i)
    (q_ff.mode[MODE_DBGHLT] && debug_i) |-> !tick;
  endproperty
  a_debug_halt: assert property (p_debug_halt)
    else $error("counter ticked in debug halt");

  property p_idle_halt;
    @(posedge clk_i) disable iff (rst_i)
    (q_ff.mode[MODE_IDLEHLT] && idle_i) |-> !tick;
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("counter ticked in idle halt");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && ack_o) |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

endmodule
